// ==== rtl/empc_pkg.sv ====
package empc_pkg;

  // register select codes on the core's X data I/O port
  localparam logic [2:0] SEL_CLOCK_GEN   = 3'h0;
  localparam logic [2:0] SEL_BUS_WAIT    = 3'h1;
  localparam logic [2:0] SEL_ATTR_0      = 3'h2;
  localparam logic [2:0] SEL_ATTR_3      = 3'h5;
  localparam logic [2:0] SEL_OP_MODE     = 3'h6;
  localparam logic [2:0] SEL_CORE_STATE  = 3'h7;

  // values after reset
  localparam logic [23:0] CLOCK_GEN_RST  = 24'h000000;
  localparam logic [23:0] BUS_WAIT_RST   = 24'h000000;
  localparam logic [23:0] ATTR_RST       = 24'h000000;
  localparam logic [23:0] OP_MODE_RST    = 24'h000000;
  localparam logic [23:0] CORE_STATE_RST = 24'h080000;

  // clock_gen_control fields
  localparam int MULT_LO      = 0;
  localparam int OUTDIV_LO    = 12;
  localparam int LOW_FREQ_BIT = 15;
  localparam int XDRV_OFF_BIT = 16;
  localparam int RUN_STOP_BIT = 17;
  localparam int LOOP_EN_BIT  = 18;
  localparam int CLKOUT_OFF   = 19;
  localparam int PREDIV_LO    = 20;

  // bus_wait_control fields
  localparam int WS0_LO       = 0;
  localparam int WS1_LO       = 5;
  localparam int WS2_LO       = 10;
  localparam int WS3_LO       = 13;
  localparam int WSDEF_LO     = 16;
  localparam int BUS_STATE    = 21;
  localparam int LOCK_HOLD    = 22;
  localparam int REQ_HOLD     = 23;

  // attr_area_control fields
  localparam int TYPE_LO      = 0;
  localparam int POL_BIT      = 2;
  localparam int P_EN_BIT     = 3;
  localparam int X_EN_BIT     = 4;
  localparam int Y_EN_BIT     = 5;
  localparam int SWAP_BIT     = 6;
  localparam int PACK_BIT     = 7;
  localparam int CNT_LO       = 8;
  localparam int CMP_LO       = 12;
  localparam logic [3:0] CMP_MAX = 4'hC;

  // operating_mode_control and core_state_flags fields
  localparam int MODE_LO      = 0;
  localparam int BUS_OFF_BIT  = 4;
  localparam int MEM_SW_BIT   = 7;
  localparam int TA_SYNC_BIT  = 11;
  localparam int BB_FAST_BIT  = 12;
  localparam int PRIO_OFF_BIT = 14;
  localparam int COMPAT16_BIT = 13;
  localparam int ICACHE_BIT   = 19;

  localparam logic [4:0] ASYNC_MIN_WS = 5'h01;

  typedef enum logic [1:0] {
    EMPC_SYNC_SRAM  = 2'b00,
    EMPC_ASYNC_SRAM = 2'b01,
    EMPC_DRAM       = 2'b10,
    EMPC_TYPE_RSVD  = 2'b11
  } empc_type_t;

  typedef enum logic [1:0] {
    EMPC_SPACE_P = 2'b00,
    EMPC_SPACE_X = 2'b01,
    EMPC_SPACE_Y = 2'b10
  } empc_space_t;

  typedef enum logic [1:0] {
    EMPC_IDLE   = 2'b00,
    EMPC_SETUP  = 2'b01,
    EMPC_STROBE = 2'b10,
    EMPC_HOLD   = 2'b11
  } empc_state_t;

  typedef struct packed {
    logic        write;
    logic        dma;
    empc_space_t space;
    logic [23:0] addr;
    logic [23:0] wdata;
  } empc_req_t;

  typedef struct packed {
    logic [17:0] addr;
    logic        rd_n;
    logic        wr_n;
    logic [23:0] dout;
    logic        dout_oe;
  } empc_pins_t;

endpackage

// ==== rtl/empc_port.sv ====
// Contract
// [RULE1] input clock predivided by predivide field plus one, range one to sixteen
// [RULE2] loop multiplies predivided rate by multiply field plus one
// [RULE3] output divided by two to the power of the three-bit field
// [RULE4] bits 15..19 hold crystal, drive, stop-run, loop enable, clock-out controls
// [RULE5] core rate equals input times multiply over predivide times divide; the code saturates at one tick per ref_clk cycle
// [RULE6] five-bit wait counts for areas 0 and 1 at bits 0-4, 5-9
// [RULE7] three-bit wait counts for areas 2 and 3 at bits 10-12, 13-15
// [RULE8] five-bit default wait count in bits 16-20 for unmatched accesses
// [RULE9] bus state status bit 21, lock hold bit 22, request hold bit 23
// [RULE10] attribute pin asserts only when address and space match its register
// [RULE11] two-bit type field selects sync SRAM, async SRAM or DRAM
// [RULE12] type value 01 means asynchronous SRAM
// [RULE13] bit 2 set drives the pin high while selected
// [RULE14] bits 3,4,5 permit program, X and Y space activation
// [RULE15] bit 6 places low eight address bits on high eight lines
// [RULE16] bit 7 enables packing logic for DMA accesses
// [RULE17] compare count high address bits, zero to twelve, against upper field
// [RULE18] mode in bits 0-3; bit 4 disables the external bus
// [RULE19] mode bits 7, 11, 12: memory switch, acknowledge sync, bus release
// [RULE20] mode bit 14 removes priority among attribute pins
// [RULE21] state bit 13 sixteen-bit mode; bit 19 enables instruction cache
// [RULE22] async accesses always get at least one wait state
// [RULE23] read: address, strobe low, capture data as strobe rises
// [RULE24] write: address, strobe, data, strobe off, address off, data held
// [RULE25] each wait state lengthens the strobe phase by one core cycle; the code strobes for the count, at least one cycle
`timescale 1ns/1ps
`default_nettype none

module empc_port (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               io_wr,
  input  wire logic               io_rd,
  input  wire logic [2:0]         io_sel,
  input  wire logic [23:0]        io_wdata,
  output logic      [23:0]        io_rdata,
  input  wire logic               acc_req,
  input  wire empc_pkg::empc_req_t acc,
  output logic                    acc_busy,
  output logic                    acc_done,
  output logic      [23:0]        acc_rdata,
  output logic                    pack_enable,
  output empc_pkg::empc_pins_t    ext,
  input  wire logic [23:0]        ext_din,
  output logic      [3:0]         attr_select_pins,
  output logic                    core_tick,
  output logic      [4:0]         clk_ctrl_bits,
  output logic      [3:0]         op_mode_select,
  output logic                    mem_switch,
  output logic                    ta_sync_sel,
  output logic                    bb_fast_release,
  output logic                    bus_lock_hold,
  output logic                    bus_req_hold,
  output logic                    compat16_mode,
  output logic                    icache_enable
);

  logic [23:0] clock_gen_control;
  logic [23:0] bus_wait_control;
  logic [23:0] attr_area_control [4];
  logic [23:0] operating_mode_control;
  logic [23:0] core_state_flags;

  empc_pkg::empc_state_t state;
  empc_pkg::empc_req_t   cur;
  logic [4:0]            ws_left;
  logic [3:0]            hit_q;
  logic [3:0]            pol_q;
  logic [17:0]           addr_q;

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------
  function automatic logic area_match(input logic [23:0] r,
                                      input empc_pkg::empc_req_t q);
    logic [3:0]  n;
    logic [11:0] mask;
    logic        sp;
    n = (r[empc_pkg::CNT_LO +: 4] > empc_pkg::CMP_MAX) ?
        empc_pkg::CMP_MAX : r[empc_pkg::CNT_LO +: 4];
    mask = ~(12'hFFF >> n); // only the top n bits take part
    unique case (q.space)
      empc_pkg::EMPC_SPACE_P: sp = r[empc_pkg::P_EN_BIT];
      empc_pkg::EMPC_SPACE_X: sp = r[empc_pkg::X_EN_BIT];
      empc_pkg::EMPC_SPACE_Y: sp = r[empc_pkg::Y_EN_BIT];
      default:                sp = 1'b0;
    endcase
    area_match = sp &&                                           // [RULE14]
      ((q.addr[23:12] & mask) ==
       (r[empc_pkg::CMP_LO +: 12] & mask));                      // [RULE17]
  endfunction

  function automatic logic [4:0] area_ws(input logic [23:0] b,
                                         input logic [1:0]  i);
    unique case (i)
      2'h0: area_ws = b[empc_pkg::WS0_LO +: 5];                  // [RULE6]
      2'h1: area_ws = b[empc_pkg::WS1_LO +: 5];                  // [RULE6]
      2'h2: area_ws = {2'h0, b[empc_pkg::WS2_LO +: 3]};          // [RULE7]
      2'h3: area_ws = {2'h0, b[empc_pkg::WS3_LO +: 3]};          // [RULE7]
    endcase
  endfunction

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clock_gen_control <= empc_pkg::CLOCK_GEN_RST;
    end else if (io_wr && io_sel == empc_pkg::SEL_CLOCK_GEN) begin
      clock_gen_control <= io_wdata;                             // [RULE4]
    end
  end

  // bus state status is not writable; it mirrors the engine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_wait_control <= empc_pkg::BUS_WAIT_RST;
    end else begin
      if (io_wr && io_sel == empc_pkg::SEL_BUS_WAIT) begin
        bus_wait_control <= io_wdata;
      end
      bus_wait_control[empc_pkg::BUS_STATE] <=
        (state != empc_pkg::EMPC_IDLE);                          // [RULE9]
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_attr
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          attr_area_control[g] <= empc_pkg::ATTR_RST;
        end else if (io_wr &&
                     io_sel == empc_pkg::SEL_ATTR_0 + 3'(g)) begin
          attr_area_control[g] <= io_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      operating_mode_control <= empc_pkg::OP_MODE_RST;
    end else if (io_wr && io_sel == empc_pkg::SEL_OP_MODE) begin
      operating_mode_control <= io_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_state_flags <= empc_pkg::CORE_STATE_RST;
    end else if (io_wr && io_sel == empc_pkg::SEL_CORE_STATE) begin
      core_state_flags <= io_wdata;
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_rdata <= 24'h000000;
    end else if (io_rd) begin
      unique case (io_sel)
        empc_pkg::SEL_CLOCK_GEN:  io_rdata <= clock_gen_control;
        empc_pkg::SEL_BUS_WAIT:   io_rdata <= bus_wait_control;
        empc_pkg::SEL_OP_MODE:    io_rdata <= operating_mode_control;
        empc_pkg::SEL_CORE_STATE: io_rdata <= core_state_flags;
        default: io_rdata <= attr_area_control[2'(io_sel - 3'h2)];
      endcase
    end
  end

  // ------------------------------------------------------------
  // core clock rate
  // ------------------------------------------------------------
  // the core rate is realised as an enable on ref_clk: a phase
  // accumulator adds MF and wraps at PREDIVIDE_FACTOR*DF. rates above ref_clk
  // saturate at one tick per cycle, a limit of one-clock design.
  logic [12:0] mult_factor;
  logic [4:0]  prediv_factor;
  logic [7:0]  outdiv_factor;
  logic [12:0] den;
  logic [13:0] phase;
  logic [13:0] phase_sum;

  always_comb begin
    prediv_factor = {1'b0, clock_gen_control[empc_pkg::PREDIV_LO +: 4]}
                    + 5'h01;                                     // [RULE1]
    mult_factor = clock_gen_control[empc_pkg::LOOP_EN_BIT] ?
      {1'b0, clock_gen_control[empc_pkg::MULT_LO +: 12]} + 13'h0001 :
      13'h0001;                                                  // [RULE2]
    outdiv_factor = 8'h01 <<
      clock_gen_control[empc_pkg::OUTDIV_LO +: 3];               // [RULE3]
    den = 13'(prediv_factor * outdiv_factor);                    // [RULE5]
    phase_sum = phase + {1'b0, mult_factor};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase     <= 14'h0000;
      core_tick <= 1'b0;
    end else if (phase_sum >= {1'b0, den}) begin
      // one tick per wrap; excess beyond one wrap is dropped
      phase     <= (phase_sum - {1'b0, den} >= {1'b0, den}) ?
                   14'h0000 : phase_sum - {1'b0, den};           // [RULE5]
      core_tick <= 1'b1;
    end else begin
      phase     <= phase_sum;
      core_tick <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // area decode for a new request
  // ------------------------------------------------------------
  logic [3:0] hit_raw;
  logic [3:0] hit_sel;
  logic [1:0] first_idx;
  logic [4:0] ws_pick;
  logic       swap_pick;
  logic       pack_pick;
  logic [1:0] type_pick;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hit_raw[i] = area_match(attr_area_control[i], acc);        // [RULE10]
    end
    first_idx = hit_raw[0] ? 2'h0 : hit_raw[1] ? 2'h1 :
                hit_raw[2] ? 2'h2 : 2'h3;
    if (operating_mode_control[empc_pkg::PRIO_OFF_BIT]) begin
      hit_sel = hit_raw;                                         // [RULE20]
    end else begin
      hit_sel = hit_raw & ~(hit_raw - 4'h1); // lowest index wins
    end
    if (hit_raw != 4'h0) begin
      ws_pick   = area_ws(bus_wait_control, first_idx);
      type_pick = attr_area_control[first_idx][empc_pkg::TYPE_LO +: 2];
      swap_pick = attr_area_control[first_idx][empc_pkg::SWAP_BIT];
      pack_pick = attr_area_control[first_idx][empc_pkg::PACK_BIT];
    end else begin
      ws_pick   = bus_wait_control[empc_pkg::WSDEF_LO +: 5];     // [RULE8]
      type_pick = empc_pkg::EMPC_ASYNC_SRAM;
      swap_pick = 1'b0;
      pack_pick = 1'b0;
    end
    // sync and DRAM types run the plain strobe sequence with the
    // programmed count; only async forces the stable-address wait
    if (type_pick == empc_pkg::EMPC_ASYNC_SRAM &&
        ws_pick < empc_pkg::ASYNC_MIN_WS) begin                  // [RULE11]
      ws_pick = empc_pkg::ASYNC_MIN_WS;                          // [RULE12] [RULE22]
    end
  end

  // ------------------------------------------------------------
  // external access engine, stepped by core_tick
  // ------------------------------------------------------------
  logic bus_off;
  assign bus_off = operating_mode_control[empc_pkg::BUS_OFF_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state       <= empc_pkg::EMPC_IDLE;
      cur         <= '0;
      ws_left     <= 5'h00;
      hit_q       <= 4'h0;
      addr_q      <= 18'h00000;
      pack_enable <= 1'b0;
      acc_done    <= 1'b0;
      acc_rdata   <= 24'h000000;
    end else begin
      acc_done <= 1'b0;
      // the last sample taken under the strobe is the one kept
      if (!ext.rd_n) begin
        acc_rdata <= ext_din;                                    // [RULE23]
      end
      if (core_tick) begin
        unique case (state)
          empc_pkg::EMPC_IDLE: begin
            if (acc_req && bus_off) begin
              acc_done <= 1'b1; // refused, no bus cycle      [RULE18]
            end else if (acc_req) begin
              state   <= empc_pkg::EMPC_SETUP;
              cur     <= acc;
              ws_left <= ws_pick;
              hit_q   <= hit_sel;
              addr_q  <= swap_pick ?
                         {acc.addr[7:0], acc.addr[9:0]} :         // [RULE15]
                         acc.addr[17:0];
              pack_enable <= pack_pick && acc.dma;               // [RULE16]
            end
          end
          empc_pkg::EMPC_SETUP: begin
            state <= empc_pkg::EMPC_STROBE;                      // [RULE23] [RULE24]
          end
          empc_pkg::EMPC_STROBE: begin
            if (ws_left > 5'h01) begin
              ws_left <= ws_left - 5'h01;                        // [RULE25]
            end else begin
              state <= empc_pkg::EMPC_HOLD; // [RULE23] [RULE24]
            end
          end
          empc_pkg::EMPC_HOLD: begin
            state       <= empc_pkg::EMPC_IDLE;
            acc_done    <= 1'b1;
            hit_q       <= 4'h0;
            pack_enable <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // pin drive, registered
  // ------------------------------------------------------------
  // attribute pins drop with the strobe on a write so the select
  // goes away before the data, which stays one more core cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext <= '{addr: 18'h00000, rd_n: 1'b1, wr_n: 1'b1,
               dout: 24'h000000, dout_oe: 1'b0};
    end else begin
      ext.addr    <= (state == empc_pkg::EMPC_IDLE) ? ext.addr : addr_q;
      ext.rd_n    <= !(state == empc_pkg::EMPC_STROBE && !cur.write);
      ext.wr_n    <= !(state == empc_pkg::EMPC_STROBE && cur.write);
      ext.dout    <= cur.wdata;
      ext.dout_oe <= cur.write &&
                     (state == empc_pkg::EMPC_STROBE ||
                      state == empc_pkg::EMPC_HOLD);             // [RULE24]
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pol_q[i] = attr_area_control[i][empc_pkg::POL_BIT];
    end
  end

  generate
    for (g = 0; g < 4; g++) begin : g_pin
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          attr_select_pins[g] <= 1'b1;
        end else begin
          // active level follows polarity, idle level its inverse
          attr_select_pins[g] <=
            ((state == empc_pkg::EMPC_SETUP ||
              state == empc_pkg::EMPC_STROBE) && hit_q[g]) ?
            pol_q[g] : !pol_q[g];                                // [RULE10] [RULE13]
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // control bits out to the rest of the chip
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_busy        <= 1'b0;
      clk_ctrl_bits   <= 5'h00;
      op_mode_select  <= 4'h0;
      mem_switch      <= 1'b0;
      ta_sync_sel     <= 1'b0;
      bb_fast_release <= 1'b0;
      bus_lock_hold   <= 1'b0;
      bus_req_hold    <= 1'b0;
      compat16_mode   <= 1'b0;
      icache_enable   <= 1'b0;
    end else begin
      acc_busy        <= (state != empc_pkg::EMPC_IDLE);
      clk_ctrl_bits   <=
        clock_gen_control[empc_pkg::LOW_FREQ_BIT +: 5];          // [RULE4]
      op_mode_select  <=
        operating_mode_control[empc_pkg::MODE_LO +: 4];          // [RULE18]
      mem_switch      <=
        operating_mode_control[empc_pkg::MEM_SW_BIT];            // [RULE19]
      ta_sync_sel     <=
        operating_mode_control[empc_pkg::TA_SYNC_BIT];           // [RULE19]
      bb_fast_release <=
        operating_mode_control[empc_pkg::BB_FAST_BIT];           // [RULE19]
      bus_lock_hold   <= bus_wait_control[empc_pkg::LOCK_HOLD];  // [RULE9]
      bus_req_hold    <= bus_wait_control[empc_pkg::REQ_HOLD];   // [RULE9]
      compat16_mode   <= core_state_flags[empc_pkg::COMPAT16_BIT]; // [RULE21]
      icache_enable   <= core_state_flags[empc_pkg::ICACHE_BIT];   // [RULE21]
    end
  end

endmodule

`default_nettype wire

// ==== testbench/empc_port_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module empc_port_props (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 io_wr,
  input wire logic                 io_rd,
  input wire logic [2:0]           io_sel,
  input wire logic [23:0]          io_wdata,
  input wire logic [23:0]          io_rdata,
  input wire empc_pkg::empc_pins_t ext,
  input wire logic [4:0]           clk_ctrl_bits,
  input wire logic [3:0]           op_mode_select,
  input wire logic                 bus_lock_hold,
  input wire logic                 compat16_mode,
  input wire logic                 icache_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic wr_cg = io_wr && io_sel == empc_pkg::SEL_CLOCK_GEN;
  wire logic wr_bw = io_wr && io_sel == empc_pkg::SEL_BUS_WAIT;
  wire logic wr_om = io_wr && io_sel == empc_pkg::SEL_OP_MODE;
  wire logic wr_cs = io_wr && io_sel == empc_pkg::SEL_CORE_STATE;
  wire logic wr_a0 = io_wr && io_sel == empc_pkg::SEL_ATTR_0;
  wire logic rd_a0 = io_rd && !io_wr && io_sel == empc_pkg::SEL_ATTR_0;
  // ---------------------------------------------
  // external strobes
  // ---------------------------------------------
  chk_strobe_excl: assert property (!(!ext.rd_n && !ext.wr_n))
    else $error("read and write strobes low together");
  chk_read_float: assert property (!ext.rd_n |-> !ext.dout_oe)
    else $error("data driven during read");
  chk_write_drive: assert property (!ext.wr_n |-> ext.dout_oe)
    else $error("write strobe without data");
  chk_data_hold: assert property ($rose(ext.wr_n) |-> ext.dout_oe)
    else $error("data dropped with write strobe");
  chk_addr_steady: assert property ((!ext.rd_n || !ext.wr_n) |->
    $stable(ext.addr)) else $error("address moved under strobe");
  // ---------------------------------------------
  // register copies
  // ---------------------------------------------
  chk_clk_copy: assert property (wr_cg |-> ##2
    clk_ctrl_bits == $past(io_wdata[19:15], 2))
    else $error("clock control bits not copied");
  chk_mode_copy: assert property (wr_om |-> ##2
    op_mode_select == $past(io_wdata[3:0], 2))
    else $error("mode select not copied");
  chk_lock_copy: assert property (wr_bw |-> ##2
    bus_lock_hold == $past(io_wdata[22], 2))
    else $error("lock hold not copied");
  chk_state_copy: assert property (wr_cs |-> ##2
    {icache_enable, compat16_mode} ==
    {$past(io_wdata[19], 2), $past(io_wdata[13], 2)})
    else $error("state flags not copied");
  chk_attr_readback: assert property (wr_a0 ##2 rd_a0 |=>
    io_rdata == $past(io_wdata, 3)) else $error("attr readback wrong");
  cover property ($fell(ext.rd_n));
  cover property ($fell(ext.wr_n));
  cover property (wr_a0 ##2 rd_a0);
endmodule
bind empc_port empc_port_props u_props (.ref_clk, .rst, .io_wr, .io_rd,
  .io_sel, .io_wdata, .io_rdata, .ext, .clk_ctrl_bits, .op_mode_select,
  .bus_lock_hold, .compat16_mode, .icache_enable);
`default_nettype wire

// ==== testbench/empc_sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module empc_sram_model (
  input  wire logic                 ref_clk,
  input  wire empc_pkg::empc_pins_t ext,
  input  wire logic                 cs_n,
  input  wire logic                 slow,
  output logic [23:0]               ext_din
);
  logic [23:0] mem [0:255];
  logic [23:0] last;
  logic        first;
  // ---------------------------------------------
  // storage and read drive
  // ---------------------------------------------
  // last edge under the strobe wins, data is held to the end
  always @(posedge ref_clk) begin
    if (!ext.wr_n && !cs_n) mem[ext.addr[7:0]] <= ext.dout;
    last  <= ext_din;
    first <= ext.rd_n;
  end
  // slow part: nothing valid in the first strobe cycle
  always_comb begin
    if (!ext.rd_n && !cs_n && !(slow && first)) ext_din = mem[ext.addr[7:0]];
    else ext_din = ~last;
  end
endmodule
`default_nettype wire

// ==== testbench/empc_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module empc_port_tb;
  logic ref_clk = 0, rst = 1, io_wr = 0, io_rd = 0, acc_req = 0, slow = 0;
  logic [2:0]  io_sel = 3'h0;
  logic [23:0] io_wdata = 24'h000000, io_rdata, acc_rdata, ext_din, rv;
  empc_pkg::empc_req_t  acc = '0;
  empc_pkg::empc_pins_t ext;
  logic acc_busy, acc_done, pack_enable, core_tick, mem_switch, ta_sync_sel;
  logic bb_fast_release, bus_lock_hold, bus_req_hold, compat16_mode;
  logic icache_enable;
  logic [3:0]  attr_select_pins, op_mode_select, pins_low;
  logic [4:0]  clk_ctrl_bits;
  logic [23:0] cg [4] = '{24'h100000, 24'h041001, 24'h342001, 24'h003000};
  int          tk [4] = '{32, 64, 8, 8};
  int mismatches = 0, comparisons = 0, strobes, s1, n;
  always #2.5 ref_clk = ~ref_clk;
  empc_port u_dut (.ref_clk, .rst, .io_wr, .io_rd, .io_sel, .io_wdata,
    .io_rdata, .acc_req, .acc, .acc_busy, .acc_done, .acc_rdata,
    .pack_enable, .ext, .ext_din, .attr_select_pins, .core_tick,
    .clk_ctrl_bits, .op_mode_select, .mem_switch, .ta_sync_sel,
    .bb_fast_release, .bus_lock_hold, .bus_req_hold, .compat16_mode,
    .icache_enable);
  empc_sram_model u_mem (.ref_clk, .ext, .cs_n(attr_select_pins[0]), .slow,
    .ext_din);
  always @(posedge ref_clk) begin
    if (!ext.rd_n || !ext.wr_n) strobes++;
    pins_low |= ~attr_select_pins;
  end
  // ---------------------------------------------
  // access tasks
  // ---------------------------------------------
  task check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task reg_wr(input logic [2:0] s, input logic [23:0] d);
    @(negedge ref_clk); io_wr = 1; io_sel = s; io_wdata = d;
    @(negedge ref_clk); io_wr = 0;
  endtask
  task reg_rd(input logic [2:0] s, output logic [23:0] d);
    @(negedge ref_clk); io_rd = 1; io_sel = s;
    @(negedge ref_clk); io_rd = 0;
    @(negedge ref_clk); d = io_rdata;
  endtask
  // request held until the engine shows it was taken
  task access(input logic w, input logic [1:0] sp, input logic [23:0] a,
              input logic [23:0] d, output logic [23:0] q);
    @(negedge ref_clk); acc_req = 1; acc.write = w; acc.addr = a;
    acc.space = empc_pkg::empc_space_t'(sp); acc.wdata = d;
    strobes = 0; pins_low = 4'h0; n = 0;
    while (!acc_busy && !acc_done && n < 50) begin
      @(negedge ref_clk); n++;
    end
    acc_req = 0;
    while (!acc_done && n < 300) begin
      @(negedge ref_clk); n++;
    end
    q = acc_rdata;
    check(n < 300, 24'h000001);
    repeat (2) @(negedge ref_clk);
  endtask
  task give_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000; mismatches++; give_verdict();
  end
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 0;
    for (int i = 0; i < 8; i++) begin
      reg_rd(i[2:0], rv);
      check(rv, (i == 7) ? 24'h080000 : 24'h000000);
    end
    check(attr_select_pins, 24'h00000F);
    check(icache_enable, 24'h000001);
    $display("test reset values done");
    reg_wr(empc_pkg::SEL_CLOCK_GEN, 24'h0F8000);
    reg_rd(empc_pkg::SEL_CLOCK_GEN, rv);
    check(rv, 24'h0F8000);
    check(clk_ctrl_bits, 24'h00001F);
    for (int i = 0; i < 4; i++) begin
      reg_wr(empc_pkg::SEL_CLOCK_GEN, cg[i]);
      repeat (4) @(negedge ref_clk);
      n = 0;
      repeat (64) begin @(negedge ref_clk); n += core_tick; end
      check(n, tk[i]);
    end
    reg_wr(empc_pkg::SEL_CLOCK_GEN, 24'h000000);
    reg_wr(empc_pkg::SEL_BUS_WAIT, 24'hFFFFFF);
    reg_rd(empc_pkg::SEL_BUS_WAIT, rv);
    check(rv, 24'hDFFFFF);
    check({bus_lock_hold, bus_req_hold}, 24'h000003);
    reg_wr(empc_pkg::SEL_OP_MODE, 24'h00589F);
    reg_rd(empc_pkg::SEL_OP_MODE, rv);
    check(rv, 24'h00589F);
    check({op_mode_select, mem_switch, ta_sync_sel, bb_fast_release},
          24'h00007F);
    reg_wr(empc_pkg::SEL_CORE_STATE, 24'h002000);
    repeat (2) @(negedge ref_clk);
    check({compat16_mode, icache_enable}, 24'h000002);
    access(0, 2'h0, 24'h100005, 24'h0, rv);
    check(strobes, 24'h0);
    check(pins_low, 24'h0);
    $display("test register fields done");
    reg_wr(empc_pkg::SEL_OP_MODE, 24'h004000);
    reg_wr(empc_pkg::SEL_ATTR_0, 24'h100909);
    reg_rd(empc_pkg::SEL_ATTR_0, rv);
    check(rv, 24'h100909);
    reg_wr(empc_pkg::SEL_BUS_WAIT, 24'h000001);
    access(1, 2'h0, 24'h100005, 24'hA5A5A5, rv);
    check(pins_low[0], 24'h1);
    access(0, 2'h0, 24'h100005, 24'h0, rv);
    check(rv, 24'hA5A5A5);
    s1 = strobes;
    access(0, 2'h1, 24'h100005, 24'h0, rv);
    check(pins_low[0], 24'h0);
    access(0, 2'h0, 24'h108005, 24'h0, rv);
    check(pins_low[0], 24'h0);
    reg_wr(empc_pkg::SEL_BUS_WAIT, 24'h000000);
    access(0, 2'h0, 24'h100005, 24'h0, rv);
    check(strobes, s1);
    $display("test area select done");
    reg_wr(empc_pkg::SEL_BUS_WAIT, 24'h000004);
    slow = 1;
    access(0, 2'h0, 24'h100005, 24'h0, rv);
    check(rv, 24'hA5A5A5);
    check(strobes, s1 + 3);
    for (int t = 0; t < 4; t++) begin
      reg_wr(empc_pkg::SEL_ATTR_0, 24'h100908 | t);
      access(0, 2'h0, 24'h100005, 24'h0, rv);
      check(pins_low[0], 24'h1);
    end
    // low address byte moves up to lines 17..10
    reg_wr(empc_pkg::SEL_ATTR_0, 24'h100949);
    access(0, 2'h0, 24'h100005, 24'h0, rv);
    check(ext.addr, 24'h001405);
    reg_wr(empc_pkg::SEL_ATTR_0, 24'h10090D);
    repeat (3) @(negedge ref_clk);
    check(attr_select_pins[0], 24'h0);
    $display("test wait states done");
    give_verdict();
  end
endmodule
`default_nettype wire
